// *** logic/ddl_lookup.sv ***
// device-to-domain table walk with its AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - originator identity is the requester number taken from each inbound request.
// - table mode 00b makes the root pointer a legacy root table base.
// - the root table is 4 KByte with 256 entries, one per bus.
// - the root entry is chosen by the bus number, upper eight identity bits.
// - in legacy mode the root entry points to the bus's context table.
// - legacy context table of 256 entries indexed by device and function bits.
// - with scalable support and mode 01b the root table is scalable format.
// - each scalable root entry holds a lower and an upper context pointer.
// - devices 0-15 use the lower table, devices 16-31 the upper one.
// - requests without space id use the context default, or 0 if unsupported.
// - space id bits 19:6 index the directory found from the context entry.
// - a present directory entry gives the table indexed by id bits 5:0.
// - the table entry gives translation type and both stage pointers.
// - extended capability bit 24 always reads zero.
// - abort mode with support aborts every request without any table read.
// - with alternative routing, device bits extend the function number.
module ddl_lookup
   import ddl_pkg::*;
(
   input wire logic clk, // 250 MHz
   input wire logic resetn, // synchronous, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address taken
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data taken
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response taken
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address taken
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data taken
   input wire logic req_valid, // inbound request present
   output logic req_ready, // lookup idle, request taken
   input wire logic [15:0] req_sid, // requester number bus:dev:fn
   input wire logic req_has_pasid, // request carries a space id
   input wire logic [19:0] req_pasid, // carried space id
   input wire logic req_ari, // requester uses alternative routing
   output logic mem_rd_valid, // table entry fetch request
   input wire logic mem_rd_ready, // fetch request taken
   output logic [63:0] mem_rd_addr, // fetch byte address
   input wire logic mem_rsp_valid, // fetched data present
   input wire logic [127:0] mem_rsp_data, // first 128 bits of the entry
   output logic res_valid, // one-cycle result pulse
   output logic res_abort, // request aborted
   output logic [2:0] res_type, // space_translation_type
   output logic [51:0] res_fs_ptr, // first-stage structure page
   output logic [51:0] res_ss_ptr, // second-stage structure page
   output logic [15:0] res_did, // domain identifier
   output logic [19:0] res_pasid, // space id used
   output logic [4:0] res_dev, // device number as interpreted
   output logic [7:0] res_fn // function number as interpreted
);
   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   logic [31:0] root_lo_r;
   logic [31:0] root_hi_r;
   logic [51:0] act_base_r;
   logic [1:0] act_mode_r;
   logic rp_set_r;
   logic [31:0] ecap_w;
   logic [31:0] rd_word;
   logic wr_go;
   logic [15:0] sid_r;
   logic [19:0] pasid_r;
   logic has_pasid_r;
   ddl_state_e st_r;
   // capability word; the obsolete extended mode bit is wired low
   always_comb begin
      ecap_w = 32'h0000_0000;
      ecap_w[DDL_ECAP_SCAL_BIT] = DDL_SCAL_SUP;
      ecap_w[DDL_ECAP_ABORT_BIT] = DDL_ABORT_SUP;
      ecap_w[DDL_ECAP_DEFID_BIT] = DDL_DEFID_SUP;
      ecap_w[DDL_ECAP_OLD_EXT_BIT] = 1'b0;
   end
   // both write channels are taken in the same cycle, one write at a time
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DDL_RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr > DDL_OFS_STATUS) ? DDL_RESP_SLVERR : DDL_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // pointer words honour byte enables; the staged pointer only takes effect on a
   // set-root-pointer command, so a half-written pointer never steers a walk
   always_ff @(posedge clk) begin
      if (!resetn) begin
         root_lo_r <= DDL_RST_ROOT_LO;
         root_hi_r <= DDL_RST_ROOT_HI;
         act_base_r <= 52'h0_0000_0000_0000;
         act_mode_r <= DDL_MODE_LEGACY;
         rp_set_r <= 1'b0;
      end else if (s_axi_awready) begin
         for (int b = 0; b < 4; b++) begin
            if (s_axi_wstrb[b] && s_axi_awaddr == DDL_OFS_ROOT_LO)
               root_lo_r[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            if (s_axi_wstrb[b] && s_axi_awaddr == DDL_OFS_ROOT_HI)
               root_hi_r[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
         end
         if (s_axi_awaddr == DDL_OFS_CMD && s_axi_wstrb[0] && s_axi_wdata[DDL_CMD_SET_ROOT_BIT]) begin
            act_base_r <= {root_hi_r, root_lo_r[31:DDL_ROOT_BASE_LSB]};
            act_mode_r <= root_lo_r[DDL_ROOT_MODE_LSB +: 2];
            rp_set_r <= 1'b1;
         end
      end
   end
   // read mux; unmapped offsets answer SLVERR with zero data
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         DDL_OFS_ROOT_LO: rd_word = root_lo_r;
         DDL_OFS_ROOT_HI: rd_word = root_hi_r;
         DDL_OFS_ECAP: rd_word = ecap_w;
         DDL_OFS_STATUS: rd_word = {27'h000_0000, act_mode_r, rp_set_r, 1'b0, st_r == DDL_ST_IDLE};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= DDL_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr > DDL_OFS_STATUS || s_axi_araddr[1:0] != 2'h0 ||
                            s_axi_araddr == DDL_OFS_CMD) ? DDL_RESP_SLVERR : DDL_RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // table walk
   // ------------------------------------------------------------------
   logic req_go;
   logic scal_mode;
   logic [127:0] d;
   assign req_go = req_valid & req_ready;
   assign scal_mode = (act_mode_r == DDL_MODE_SCALABLE) & DDL_SCAL_SUP;
   assign d = mem_rsp_data;
   // fetch address: aligned base plus index scaled by entry size
   function automatic logic [63:0] ddl_ent(input logic [51:0] base, input logic [7:0] idx,
                                           input int sh);
      ddl_ent = {base, 12'h000} + 64'(({56'h0, idx}) << sh);
   endfunction : ddl_ent

   // the walk goes one table at a time; a not-present entry ends it in abort
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= DDL_ST_IDLE;
         req_ready <= 1'b0;
         mem_rd_valid <= 1'b0;
         mem_rd_addr <= 64'h0000_0000_0000_0000;
         res_valid <= 1'b0;
         res_abort <= 1'b0;
         res_type <= 3'h0;
         res_fs_ptr <= 52'h0_0000_0000_0000;
         res_ss_ptr <= 52'h0_0000_0000_0000;
         res_did <= 16'h0000;
         res_pasid <= 20'h0_0000;
         sid_r <= 16'h0000;
         pasid_r <= 20'h0_0000;
         has_pasid_r <= 1'b0;
      end else begin
         res_valid <= 1'b0;
         if (mem_rd_valid && mem_rd_ready)
            mem_rd_valid <= 1'b0;
         unique case (st_r)
            DDL_ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_go) begin
                  req_ready <= 1'b0;
                  sid_r <= req_sid;
                  pasid_r <= req_pasid;
                  has_pasid_r <= req_has_pasid;
                  res_abort <= 1'b0;
                  res_type <= 3'h0;
                  res_fs_ptr <= 52'h0_0000_0000_0000;
                  res_ss_ptr <= 52'h0_0000_0000_0000;
                  res_did <= 16'h0000;
                  res_pasid <= req_has_pasid ? req_pasid : 20'h0_0000;
                  if (act_mode_r == DDL_MODE_LEGACY || scal_mode) begin
                     st_r <= DDL_ST_ROOT;
                     mem_rd_valid <= 1'b1;
                     mem_rd_addr <= ddl_ent(act_base_r, req_sid[15:8], DDL_SH_ROOT);
                  end else begin
                     // abort mode, or a mode this unit does not offer: no table read
                     st_r <= DDL_ST_DONE;
                     res_abort <= 1'b1;
                  end
               end
            end
            DDL_ST_ROOT: if (mem_rsp_valid) begin
               mem_rd_valid <= 1'b1;
               st_r <= DDL_ST_CTX;
               if (!scal_mode) begin
                  mem_rd_addr <= ddl_ent(d[63:12], sid_r[7:0], DDL_SH_LCTX);
                  if (!d[DDL_E_PRES]) begin
                     mem_rd_valid <= 1'b0;
                     res_abort <= 1'b1;
                     st_r <= DDL_ST_DONE;
                  end
               end else begin
                  // device bit 4 picks the upper 128-entry table
                  mem_rd_addr <= ddl_ent(sid_r[7] ? d[127:DDL_E_UPTR_LSB] : d[63:DDL_E_PTR_LSB],
                                         {1'b0, sid_r[6:0]}, DDL_SH_SCTX);
                  if (!(sid_r[7] ? d[DDL_E_UPRES] : d[DDL_E_PRES])) begin
                     mem_rd_valid <= 1'b0;
                     res_abort <= 1'b1;
                     st_r <= DDL_ST_DONE;
                  end
               end
            end
            DDL_ST_CTX: if (mem_rsp_valid) begin
               if (!d[DDL_E_PRES]) begin
                  res_abort <= 1'b1;
                  st_r <= DDL_ST_DONE;
               end else if (!scal_mode) begin
                  res_type <= DDL_TT_SECOND;
                  res_ss_ptr <= d[63:DDL_E_PTR_LSB];
                  res_did <= d[DDL_E_DID_LSB +: 16];
                  st_r <= DDL_ST_DONE;
               end else begin
                  if (!has_pasid_r) begin
                     pasid_r <= DDL_DEFID_SUP ? d[DDL_E_DEFID_LSB +: 20] : 20'h0_0000;
                     res_pasid <= DDL_DEFID_SUP ? d[DDL_E_DEFID_LSB +: 20] : 20'h0_0000;
                  end
                  mem_rd_valid <= 1'b1;
                  mem_rd_addr <= {d[63:DDL_E_PTR_LSB], 12'h000} + 64'({has_pasid_r ?
                     pasid_r[19:6] : (DDL_DEFID_SUP ? d[DDL_E_DEFID_LSB + 6 +: 14] : 14'h0000),
                     3'h0});
                  st_r <= DDL_ST_PDIR;
               end
            end
            DDL_ST_PDIR: if (mem_rsp_valid) begin
               if (!d[DDL_E_PRES]) begin
                  res_abort <= 1'b1;
                  st_r <= DDL_ST_DONE;
               end else begin
                  mem_rd_valid <= 1'b1;
                  mem_rd_addr <= ddl_ent(d[63:DDL_E_PTR_LSB], {2'h0, pasid_r[5:0]},
                                         DDL_SH_PTBL);
                  st_r <= DDL_ST_PTBL;
               end
            end
            DDL_ST_PTBL: if (mem_rsp_valid) begin
               res_abort <= ~d[DDL_E_PRES];
               res_type <= d[DDL_E_TYPE_LSB +: 3];
               res_ss_ptr <= d[63:DDL_E_PTR_LSB];
               res_fs_ptr <= d[127:DDL_E_UPTR_LSB];
               res_did <= d[DDL_E_PDID_LSB +: 16];
               st_r <= DDL_ST_DONE;
            end
            DDL_ST_DONE: begin
               res_valid <= 1'b1;
               st_r <= DDL_ST_IDLE;
            end
         endcase
      end
   end

   // device and function as the requester means them
   always_ff @(posedge clk) begin
      if (!resetn) begin
         res_dev <= 5'h00;
         res_fn <= 8'h00;
      end else if (req_go) begin
         res_dev <= req_ari ? 5'h00 : req_sid[7:3];
         res_fn <= req_ari ? req_sid[7:0] : {5'h00, req_sid[2:0]};
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   abort_no_read_a: assert property (req_go && act_mode_r == DDL_MODE_ABORT |=>
      !mem_rd_valid && st_r == DDL_ST_DONE ##1 res_valid && res_abort)
      else $error("abort mode request was not aborted at once");
   ecap_old_bit_a: assert property (s_axi_rvalid && $past(s_axi_araddr) == DDL_OFS_ECAP &&
      $rose(s_axi_rvalid) |-> !s_axi_rdata[24]) else $error("capability bit 24 read as one");
   root_fetch_addr_a: assert property ($rose(mem_rd_valid) && st_r == DDL_ST_ROOT |->
      mem_rd_addr == {act_base_r, sid_r[15:8], 4'h0}) else $error("wrong root entry address");
   legacy_walk_a: assert property (req_go && act_mode_r == DDL_MODE_LEGACY |=>
      st_r == DDL_ST_ROOT && mem_rd_valid) else $error("legacy request did not read root");
   legacy_ctx_addr_a: assert property (st_r == DDL_ST_ROOT && !scal_mode && mem_rsp_valid &&
      d[0] |=> mem_rd_addr == {$past(d[63:12]), sid_r[7:0], 4'h0})
      else $error("wrong legacy context address");
   scal_ctx_addr_a: assert property (st_r == DDL_ST_ROOT && scal_mode && mem_rsp_valid &&
      sid_r[7] && d[64] |=> mem_rd_addr == {$past(d[127:76]), sid_r[6:0], 5'h00})
      else $error("upper device did not use upper context table");
   ptbl_addr_a: assert property ($rose(mem_rd_valid) && st_r == DDL_ST_PTBL |->
      mem_rd_addr[11:0] == {pasid_r[5:0], 6'h00}) else $error("wrong table entry index");
   default_id_a: assert property (st_r == DDL_ST_CTX && scal_mode && mem_rsp_valid && d[0] &&
      !has_pasid_r |=> pasid_r == $past(d[83:64])) else $error("default space id not used");
   result_time_a: assert property (st_r == DDL_ST_PTBL && mem_rsp_valid |=>
      ##1 res_valid && res_type == $past(d[8:6], 2)) else $error("table entry type lost");
   sid_capture_a: assert property (req_go |=> sid_r == $past(req_sid))
      else $error("requester number not captured");

   legacy_done_c: cover property (st_r == DDL_ST_CTX && !scal_mode ##[1:20] res_valid);
   scal_done_c: cover property (st_r == DDL_ST_PTBL ##[1:20] res_valid && !res_abort);
   abort_done_c: cover property (req_go && act_mode_r == DDL_MODE_ABORT ##2 res_valid);
endmodule : ddl_lookup
`default_nettype wire

// *** logic/ddl_pkg.sv ***
// constants shared by the device-to-domain lookup block
`default_nettype none
package ddl_pkg;
   // register byte offsets
   localparam logic [7:0] DDL_OFS_ROOT_LO = 8'h00;
   localparam logic [7:0] DDL_OFS_ROOT_HI = 8'h04;
   localparam logic [7:0] DDL_OFS_CMD = 8'h08;
   localparam logic [7:0] DDL_OFS_ECAP = 8'h0C;
   localparam logic [7:0] DDL_OFS_STATUS = 8'h10;
   localparam logic [31:0] DDL_RST_ROOT_LO = 32'h0000_0000;
   localparam logic [31:0] DDL_RST_ROOT_HI = 32'h0000_0000;
   // fields of the root pointer low word
   localparam int DDL_ROOT_MODE_LSB = 10;
   localparam int DDL_ROOT_BASE_LSB = 12;
   localparam int DDL_CMD_SET_ROOT_BIT = 0;
   // table_mode_field encodings
   localparam logic [1:0] DDL_MODE_LEGACY = 2'h0;
   localparam logic [1:0] DDL_MODE_SCALABLE = 2'h1;
   localparam logic [1:0] DDL_MODE_ABORT = 2'h3;
   // extended_capability_register bits and reported support
   localparam int DDL_ECAP_OLD_EXT_BIT = 24;
   localparam int DDL_ECAP_SCAL_BIT = 0;
   localparam int DDL_ECAP_ABORT_BIT = 1;
   localparam int DDL_ECAP_DEFID_BIT = 2;
   localparam logic DDL_SCAL_SUP = 1'b1;
   localparam logic DDL_ABORT_SUP = 1'b1;
   localparam logic DDL_DEFID_SUP = 1'b1;
   // entry size as a shift: 16, 16, 32, 8 and 64 bytes
   localparam int DDL_SH_ROOT = 4;
   localparam int DDL_SH_LCTX = 4;
   localparam int DDL_SH_SCTX = 5;
   localparam int DDL_SH_PDIR = 3;
   localparam int DDL_SH_PTBL = 6;
   // entry field positions within the first 128 bits fetched
   localparam int DDL_E_PRES = 0;
   localparam int DDL_E_PTR_LSB = 12;
   localparam int DDL_E_UPTR_LSB = 76;
   localparam int DDL_E_UPRES = 64;
   localparam int DDL_E_DID_LSB = 72;
   localparam int DDL_E_DEFID_LSB = 64;
   localparam int DDL_E_TYPE_LSB = 6;
   localparam int DDL_E_PDID_LSB = 64;
   // space_translation_type codes
   localparam logic [2:0] DDL_TT_FIRST = 3'h1;
   localparam logic [2:0] DDL_TT_SECOND = 3'h2;
   localparam logic [2:0] DDL_TT_NESTED = 3'h3;
   localparam logic [2:0] DDL_TT_PASS = 3'h4;
   localparam logic [1:0] DDL_RESP_OKAY = 2'h0;
   localparam logic [1:0] DDL_RESP_SLVERR = 2'h2;
   typedef enum logic [5:0] {
      DDL_ST_IDLE = 6'h01,
      DDL_ST_ROOT = 6'h02,
      DDL_ST_CTX = 6'h04,
      DDL_ST_PDIR = 6'h08,
      DDL_ST_PTBL = 6'h10,
      DDL_ST_DONE = 6'h20
   } ddl_state_e;
endpackage : ddl_pkg
`default_nettype wire

// *** testbench/ddl_mem_model.sv ***
// table memory model that answers the entry fetches of the lookup walk
`timescale 1ns/1ns
`default_nettype none
module ddl_mem_model (
   input wire logic clk, // walk clock
   input wire logic resetn, // synchronous, active low
   input wire logic slow, // stall each fetch a few cycles
   input wire logic mem_rd_valid, // fetch request
   output logic mem_rd_ready, // fetch taken
   input wire logic [63:0] mem_rd_addr, // fetch byte address
   output logic mem_rsp_valid, // data pulse
   output logic [127:0] mem_rsp_data // entry data
);
   logic [127:0] tbl [logic [63:0]]; // entries that software has built
   logic [63:0] last_a; // address of the fetch in flight
   logic pend; // an answer is owed
   int fetches = 0; // fetches taken so far
   int wt; // stall cycles left
   // one fetch at a time; unbuilt places read as zero, i.e. not present
   always @(posedge clk) begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= ~mem_rsp_data; // idle data changes every cycle, so it never looks valid
      if (!resetn) begin
         {mem_rd_ready, pend, mem_rsp_data} <= '0;
         wt = 0;
      end else if (pend) begin
         pend <= 1'b0;
         mem_rsp_valid <= 1'b1;
         mem_rsp_data <= tbl.exists(last_a) ? tbl[last_a] : '0;
      end else if (mem_rd_valid && mem_rd_ready) begin
         {mem_rd_ready, pend} <= 2'b01;
         last_a <= mem_rd_addr;
         fetches++;
         wt = slow ? 3 : 0;
      end else if (mem_rd_valid && wt == 0) begin
         mem_rd_ready <= 1'b1;
      end else begin
         wt = mem_rd_valid ? wt - 1 : (slow ? 3 : 0);
      end
   end
endmodule : ddl_mem_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the device-to-domain lookup
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ddl_pkg::*;
   logic clk, resetn, slow;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic req_valid, req_ready, req_has_pasid, req_ari, mem_rd_valid, mem_rd_ready, mem_rsp_valid;
   logic [15:0] req_sid, res_did;
   logic [19:0] req_pasid, res_pasid;
   logic [63:0] mem_rd_addr;
   logic [127:0] mem_rsp_data;
   logic res_valid, res_abort;
   logic [2:0] res_type, t;
   logic [51:0] res_fs_ptr, res_ss_ptr;
   logic [4:0] res_dev;
   logic [7:0] res_fn;
   logic [2:0] tt [4] = '{DDL_TT_FIRST, DDL_TT_SECOND, DDL_TT_NESTED, DDL_TT_PASS};
   int fails = 0, check_count = 0, cyc = 0, n;

   ddl_lookup dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .req_valid, .req_ready, .req_sid, .req_has_pasid, .req_pasid, .req_ari,
      .mem_rd_valid, .mem_rd_ready, .mem_rd_addr, .mem_rsp_valid, .mem_rsp_data, .res_valid,
      .res_abort, .res_type, .res_fs_ptr, .res_ss_ptr, .res_did, .res_pasid, .res_dev, .res_fn);
   ddl_mem_model mm (.clk, .resetn, .slow, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr,
      .mem_rsp_valid, .mem_rsp_data);

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // a hang is cut short well past the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         complete_run;
      end
   end

   // ------------------------------
   // tasks
   // ------------------------------
   task automatic complete_run;
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      // each channel is released at the edge that takes it, in whatever order
      fork
         begin
            do @(posedge clk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge clk); while (s_axi_wready !== 1'b1);
            s_axi_wvalid <= 1'b0;
         end
      join
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      {v, rs} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : axr

   // stage the root pointer and mode, then make it active
   task automatic setmode(input logic [1:0] m);
      logic [1:0] rs;
      axw(DDL_OFS_ROOT_LO, 32'h0001_0000 | (32'(m) << DDL_ROOT_MODE_LSB), rs);
      axw(DDL_OFS_CMD, 32'h0000_0001, rs);
   endtask : setmode

   task automatic lookup(input logic [15:0] sid, input logic hp, input logic [19:0] p,
                         input logic ari);
      @(posedge clk);
      {req_sid, req_has_pasid, req_pasid, req_ari, req_valid} <= {sid, hp, p, ari, 1'b1};
      do @(posedge clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      do @(posedge clk); while (res_valid !== 1'b1);
   endtask : lookup

   task automatic chkres(input logic [2:0] ty, input logic [51:0] ss, input logic [15:0] did);
      chk("res_abort", 1'b0, res_abort);
      chk("res_type", ty, res_type);
      chk("res_ss_ptr", ss, res_ss_ptr);
      chk("res_did", did, res_did);
   endtask : chkres

   function automatic logic [127:0] ent(input logic [51:0] p, input logic [63:0] hi,
                                        input logic [11:0] lo);
      return {hi, p, lo};
   endfunction : ent

   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {req_valid, req_has_pasid, req_ari, slow, resetn} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, req_sid, req_pasid} = '0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      axr(DDL_OFS_ECAP, d, r);
      chk("ecap", 32'h0000_0007, d);
      axr(DDL_OFS_ROOT_LO, d, r);
      chk("root_lo", DDL_RST_ROOT_LO, d);
      axr(8'h14, d, r);
      chk("rresp", DDL_RESP_SLVERR, r);
      axw(8'h14, 32'hFFFF_FFFF, r);
      chk("bresp", DDL_RESP_SLVERR, r);
      // abort mode first, while the tables are still unbuilt
      setmode(DDL_MODE_ABORT);
      axr(DDL_OFS_STATUS, d, r);
      chk("status", 32'h0000_001D, d);
      n = mm.fetches;
      lookup(16'h122B, 1'b0, 20'h0, 1'b0);
      chk("res_abort", 1'b1, res_abort);
      chk("fetches", n, mm.fetches);
      // legacy tables: two functions of one domain share every pointer
      mm.tbl[64'h1_0120] = ent(52'h20, 64'h0, 12'h001);
      mm.tbl[64'h2_02B0] = ent(52'h55, {40'h0, 16'h0042, 8'h00}, 12'h001);
      mm.tbl[64'h2_02C0] = mm.tbl[64'h2_02B0];
      setmode(DDL_MODE_LEGACY);
      for (int i = 0; i < 3; i++) begin
         slow <= (i == 1);
         lookup(16'h122B + 16'(i % 2), 1'b0, 20'h0, i == 2);
         chkres(DDL_TT_SECOND, 52'h55, 16'h0042);
         chk("res_dev", (i == 2) ? 5'h00 : 5'h05, res_dev);
         chk("res_fn", (i == 2) ? 8'h2B : 8'h03 + 8'(i), res_fn);
      end
      // scalable tables: an upper and a lower device reach one directory
      mm.tbl[64'h1_0030] = ent(52'h30, {52'h31, 11'h0, 1'b1}, 12'h001);
      mm.tbl[64'h3_1420] = ent(52'h40, 64'h0C5, 12'h001);
      mm.tbl[64'h3_0200] = ent(52'h40, 64'hF_FFFF, 12'h001);
      mm.tbl[64'h4_0018] = ent(52'h50, 64'h0, 12'h001);
      setmode(DDL_MODE_SCALABLE);
      for (int i = 0; i < 5; i++) begin
         t = tt[i % 4];
         mm.tbl[64'h5_0140] = ent(52'h66, {52'h77770, 12'hABC}, {3'h0, t, 6'h01});
         slow <= i[0];
         lookup((i < 4) ? 16'h03A1 : 16'h0310, i == 4, (i == 4) ? 20'h000C5 : 20'h0, 1'b0);
         chkres(t, 52'h66, 16'h0ABC);
         chk("res_fs_ptr", 52'h77770, res_fs_ptr);
         chk("res_pasid", 20'h000C5, res_pasid);
      end
      // a bus whose root entry was never built reads as not present
      lookup(16'h0710, 1'b0, 20'h0, 1'b0);
      chk("res_abort", 1'b1, res_abort);
      // the unused mode code behaves like abort mode: no table read at all
      setmode(2'h2);
      n = mm.fetches;
      lookup(16'h03A1, 1'b0, 20'h0, 1'b0);
      chk("res_abort", 1'b1, res_abort);
      chk("fetches", n, mm.fetches);
      complete_run;
   end
endmodule : tb_top
`default_nettype wire
